// ==== src/glue_device.sv ====
// Board glue: selects, board-to-host I/O registers and UART acknowledge cycles
`timescale 1ns/1ns
// Operation
// - Local RAM: host in download, processor otherwise
// - Processor enables lower select after reset
// - Dual-port RAM on first mid select
// - Mid select external ready, fixed base
// - UARTs only on second mid select
// - Four UARTs at 100H spacing
// - UART registers byte-wide on even addresses
// - ISA write 400H sets program ready
// - ISA bit0 low-high edge latches host interrupt
// - ISA bit1 low enables host interrupt
// - Processor writes 00H then 03H
// - EISA write 400H sets board ready
// - EISA write 480H posts host interrupt
// - Receive, transmit, modem interrupts to inputs 0-2
// - Acknowledge reads at offsets 0, 2, 4
// - Acknowledge cycles end through external ready
// - Host leaves download to release processor
// - Host reset holds processor at least 500ns
module glue_device
	import glue_pkg::*;
#(
	parameter glue_pkg::variant_t VARIANT = glue_pkg::VAR_ISA
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	glue_if.device bus,
	input wire logic download_pin,
	input wire logic host_reset_pin,
	input wire logic host_irq_clear_pin,
	input wire logic rx_irq_pin,
	input wire logic tx_irq_pin,
	input wire logic modem_irq_pin,
	input wire logic [7:0] ram_rdata,
	input wire logic [7:0] dp_rdata,
	input wire logic [7:0] uart_rdata,
	output logic ram_cpu_en,
	output logic ram_host_en,
	output logic ram_we,
	output logic [15:0] ram_addr,
	output logic dp_en,
	output logic dp_we,
	output logic [17:0] dp_addr,
	output logic [3:0] uart_cs,
	output logic uart_rd,
	output logic uart_wr,
	output logic [6:0] uart_off,
	output logic [2:0] uart_ack,
	output logic [7:0] wdata_out,
	output logic program_ready,
	output logic host_irq
);
	import glue_pkg::*;

	localparam int NPIN = 6;
	localparam int DP_AW = (VARIANT == VAR_EISA) ? DP_AW_EISA :
		(VARIANT == VAR_ISA_LARGE) ? DP_AW_ISA_LARGE : DP_AW_ISA;
	localparam logic [4:0] HOLD_LOAD = 5'(HOST_RESET_CYC);

	logic [NPIN-1:0] pin_meta_r;
	logic [NPIN-1:0] pin_s_r;
	logic download_s, host_reset_s, irq_clear_s;
	logic dl_prev_r;
	logic [4:0] hold_cnt_r;
	logic cpu_hold_r;
	glue_state_t state_r;
	src_t src_r;
	logic ext_r;
	logic ready_r;
	logic [7:0] rdata_r;
	logic [1:0] irq_reg_r;
	logic ready_flag_r;
	logic host_irq_r;
	logic any_strobe, mem_acc, start;
	logic io_wr_start, hit_ready, hit_int;

	wire [NPIN-1:0] pins = {modem_irq_pin, tx_irq_pin, rx_irq_pin,
		host_irq_clear_pin, host_reset_pin, download_pin};

	// Every pin is foreign to clk: two stages before anything looks at it
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_sync
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					pin_meta_r[gi] <= 1'b0;
					pin_s_r[gi] <= 1'b0;
				end else if (ce) begin
					pin_meta_r[gi] <= pins[gi];
					pin_s_r[gi] <= pin_meta_r[gi];
				end
			end
		end
	endgenerate

	assign download_s = pin_s_r[0];
	assign host_reset_s = pin_s_r[1];
	assign irq_clear_s = pin_s_r[2];

	// Stretch the host reset so the processor sees the full minimum hold
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hold_cnt_r <= 5'h00;
			cpu_hold_r <= 1'b1;
			dl_prev_r <= 1'b0;
		end else if (ce) begin
			dl_prev_r <= download_s;
			if (host_reset_s)
				hold_cnt_r <= HOLD_LOAD;
			else if (hold_cnt_r != 5'h00)
				hold_cnt_r <= hold_cnt_r - 5'h01;
			cpu_hold_r <= download_s | host_reset_s | (hold_cnt_r > 5'h01);
		end
	end

	assign any_strobe = bus.mem_rd | bus.mem_wr | bus.io_rd | bus.io_wr;
	assign mem_acc = bus.mem_rd | bus.mem_wr;
	assign start = (state_r == G_IDLE) && any_strobe && !cpu_hold_r;
	assign io_wr_start = start && bus.io_wr;
	assign hit_ready = io_wr_start && (bus.addr[15:0] == ((VARIANT == VAR_EISA) ?
		EISA_READY_SIGNAL : ISA_READY_SIGNAL));
	assign hit_int = io_wr_start && (bus.addr[15:0] == ((VARIANT == VAR_EISA) ?
		EISA_HOST_INTERRUPT : ISA_HOST_INTERRUPT));

	// Access sequencer: every bus cycle takes the same three edges
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= G_IDLE;
			src_r <= SRC_NONE;
			ext_r <= 1'b0;
			ready_r <= 1'b0;
			rdata_r <= 8'h00;
			ram_cpu_en <= 1'b0;
			ram_we <= 1'b0;
			ram_addr <= 16'h0000;
			dp_en <= 1'b0;
			dp_we <= 1'b0;
			dp_addr <= 18'h00000;
			uart_cs <= 4'h0;
			uart_rd <= 1'b0;
			uart_wr <= 1'b0;
			uart_off <= 7'h00;
			uart_ack <= 3'h0;
			wdata_out <= 8'h00;
		end else if (ce) begin
			if (cpu_hold_r) begin
				state_r <= G_IDLE;
				ready_r <= 1'b0;
				ram_cpu_en <= 1'b0;
				dp_en <= 1'b0;
				uart_cs <= 4'h0;
				uart_rd <= 1'b0;
				uart_wr <= 1'b0;
				uart_ack <= 3'h0;
			end else begin
				case (state_r)
					G_IDLE: begin
						if (start) begin
							state_r <= G_STROBE;
							src_r <= SRC_NONE;
							ext_r <= 1'b1;
							wdata_out <= bus.wdata;
							if (!bus.lower_mem_select_n && mem_acc && !download_s) begin
								src_r <= SRC_RAM;
								ext_r <= 1'b0;
								ram_cpu_en <= 1'b1;
								ram_we <= bus.mem_wr;
								ram_addr <= bus.addr[RAM_AW-1:0];
							end else if (!bus.dual_port_select_n && mem_acc) begin
								src_r <= SRC_DP;
								dp_en <= 1'b1;
								dp_we <= bus.mem_wr;
								dp_addr <= 18'(bus.addr[DP_AW-1:0]);
							end else if (!bus.uart_bank_select_n && mem_acc) begin
								src_r <= SRC_UART;
								// Odd addresses miss the byte lane, so they reach no UART
								if (!bus.addr[0]) begin
									uart_cs[bus.addr[9:8]] <= 1'b1;
									uart_rd <= bus.mem_rd;
									uart_wr <= bus.mem_wr;
								end
								uart_off <= bus.addr[7:1];
							end else if (!bus.ack_peripheral_select_n && bus.io_rd) begin
								src_r <= SRC_UART;
								case (bus.addr[2:0])
									UART_RECEIVE_ACK: uart_ack <= 3'b001;
									UART_TRANSMIT_ACK: uart_ack <= 3'b010;
									UART_MODEM_ACK: uart_ack <= 3'b100;
									default: src_r <= SRC_NONE;
								endcase
							end
						end
					end
					G_STROBE: begin
						case (src_r)
							SRC_RAM: rdata_r <= ram_rdata;
							SRC_DP: rdata_r <= dp_rdata;
							SRC_UART: rdata_r <= uart_rdata;
							default: rdata_r <= 8'h00;
						endcase
						ready_r <= ext_r;
						ram_cpu_en <= 1'b0;
						dp_en <= 1'b0;
						uart_cs <= 4'h0;
						uart_rd <= 1'b0;
						uart_wr <= 1'b0;
						uart_ack <= 3'h0;
						state_r <= G_DONE;
					end
					G_DONE: begin
						ready_r <= 1'b0;
						state_r <= G_RELEASE;
					end
					G_RELEASE: begin
						if (!any_strobe)
							state_r <= G_IDLE;
					end
					default: state_r <= G_IDLE;
				endcase
			end
		end
	end

	// Board-to-host registers; a set always beats a same-cycle clear
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_reg_r <= IRQ_REG_DOWNLOAD;
			ready_flag_r <= 1'b0;
			host_irq_r <= 1'b0;
		end else if (ce) begin
			if (VARIANT == VAR_EISA) begin
				if (hit_ready)
					ready_flag_r <= 1'b1;
				else if (download_s || host_reset_s)
					ready_flag_r <= 1'b0;
				if (hit_int)
					host_irq_r <= 1'b1;
				else if (irq_clear_s)
					host_irq_r <= 1'b0;
			end else begin
				if (hit_ready)
					ready_flag_r <= 1'b1;
				else if (download_s && !dl_prev_r)
					ready_flag_r <= 1'b0;
				if (download_s)
					irq_reg_r <= IRQ_REG_DOWNLOAD;
				else if (hit_int)
					irq_reg_r <= bus.wdata[1:0];
				// Edge counts only if the enable was already low before the rising write
				if (hit_int && bus.wdata[IRQ_DATA_BIT] && !irq_reg_r[IRQ_DATA_BIT] &&
					!irq_reg_r[IRQ_EN_N_BIT])
					host_irq_r <= 1'b1;
				else if (irq_clear_s)
					host_irq_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ram_host_en <= 1'b0;
			program_ready <= 1'b0;
			host_irq <= 1'b0;
			bus.rx_irq_input <= 1'b0;
			bus.tx_irq_input <= 1'b0;
			bus.modem_irq_input <= 1'b0;
		end else if (ce) begin
			ram_host_en <= download_s;
			program_ready <= ready_flag_r;
			host_irq <= host_irq_r;
			bus.rx_irq_input <= pin_s_r[3];
			bus.tx_irq_input <= pin_s_r[4];
			bus.modem_irq_input <= pin_s_r[5];
		end
	end

	assign bus.rdata = rdata_r;
	assign bus.ext_ready = ready_r;
	assign bus.cpu_hold = cpu_hold_r;
endmodule // glue_device

// ==== src/glue_pkg.sv ====
// Shared constants and types for the adapter processor glue and its processor end
package glue_pkg;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 8;
	localparam int UART_COUNT = 4;
	localparam int UART_OFF_W = 7;
	localparam int DP_AW_ISA = 14;
	localparam int DP_AW_ISA_LARGE = 18;
	localparam int DP_AW_EISA = 15;
	localparam int RAM_AW = 16;
	localparam logic [19:0] LOWER_TOP = 20'h0ffff;
	localparam logic [19:0] DP_BASE_ISA = 20'h80000;
	localparam logic [19:0] DP_BASE_OTHER = 20'h40000;
	localparam logic [19:0] UART_BASE_ISA = 20'h90000;
	localparam logic [19:0] UART_BASE_EISA = 20'h48000;
	localparam logic [19:0] UART_BASE_ALT = 20'h44000;
	localparam logic [19:0] UART_SPAN = 20'h00400;
	localparam logic [15:0] ACK_BASE_DEFAULT = 16'h0800;
	localparam logic [2:0] UART_RECEIVE_ACK = 3'h0;
	localparam logic [2:0] UART_TRANSMIT_ACK = 3'h2;
	localparam logic [2:0] UART_MODEM_ACK = 3'h4;
	localparam logic [15:0] ISA_READY_SIGNAL = 16'h0400;
	localparam logic [15:0] EISA_READY_SIGNAL = 16'h0400;
	localparam logic [15:0] ISA_HOST_INTERRUPT = 16'h0480;
	localparam logic [15:0] EISA_HOST_INTERRUPT = 16'h0480;
	localparam int IRQ_DATA_BIT = 0;
	localparam int IRQ_EN_N_BIT = 1;
	localparam logic [1:0] IRQ_REG_DOWNLOAD = 2'h3;
	localparam logic [7:0] IRQ_PULSE_LOW = 8'h00;
	localparam logic [7:0] IRQ_PULSE_HIGH = 8'h03;
	localparam int CLK_MHZ = 50;
	localparam int HOST_RESET_MIN_NS = 500;
	localparam int HOST_RESET_CYC = (HOST_RESET_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int INT_WAIT = 2;
	localparam int CFG_LOWER_EN = 0;
	localparam int CFG_MID_EN = 1;
	localparam int CFG_PERIPH_EN = 2;
	localparam int CFG_MID_EXT_RDY = 3;
	localparam int CFG_PERIPH_EXT_RDY = 4;
	typedef enum logic [1:0] {
		VAR_ISA = 2'b00,
		VAR_ISA_LARGE = 2'b01,
		VAR_EISA = 2'b10
	} variant_t;
	typedef enum logic [1:0] {
		SRC_NONE = 2'b00,
		SRC_RAM = 2'b01,
		SRC_DP = 2'b10,
		SRC_UART = 2'b11
	} src_t;
	typedef enum logic [1:0] {
		G_IDLE = 2'b00,
		G_STROBE = 2'b01,
		G_DONE = 2'b10,
		G_RELEASE = 2'b11
	} glue_state_t;
	typedef enum logic [2:0] {
		CMD_MEM_RD = 3'b000,
		CMD_MEM_WR = 3'b001,
		CMD_IO_RD = 3'b010,
		CMD_IO_WR = 3'b011,
		CMD_CFG = 3'b100,
		CMD_HOST_INT = 3'b101
	} cmd_t;
	typedef enum logic [0:0] {
		P_IDLE = 1'b0,
		P_ACCESS = 1'b1
	} proc_state_t;
endpackage

// ==== src/glue_if.sv ====
// Processor bus between the board glue logic and the embedded processor
`timescale 1ns/1ns
interface glue_if;
	logic [19:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic mem_rd;
	logic mem_wr;
	logic io_rd;
	logic io_wr;
	logic lower_mem_select_n;
	logic dual_port_select_n;
	logic uart_bank_select_n;
	logic ack_peripheral_select_n;
	logic ext_ready;
	logic cpu_hold;
	logic rx_irq_input;
	logic tx_irq_input;
	logic modem_irq_input;
	modport device (
		input addr, wdata, mem_rd, mem_wr, io_rd, io_wr,
		input lower_mem_select_n, dual_port_select_n, uart_bank_select_n,
		input ack_peripheral_select_n,
		output rdata, ext_ready, cpu_hold, rx_irq_input, tx_irq_input, modem_irq_input
	);
	modport proc (
		output addr, wdata, mem_rd, mem_wr, io_rd, io_wr,
		output lower_mem_select_n, dual_port_select_n, uart_bank_select_n,
		output ack_peripheral_select_n,
		input rdata, ext_ready, cpu_hold, rx_irq_input, tx_irq_input, modem_irq_input
	);
endinterface

// ==== src/glue_proc.sv ====
// Processor end: turns user commands into bus cycles with its own chip selects
`timescale 1ns/1ns
module glue_proc
	import glue_pkg::*;
#(
	parameter logic [19:0] MID_BASE = glue_pkg::DP_BASE_ISA,
	parameter int MID_AW = glue_pkg::DP_AW_ISA,
	parameter logic [19:0] UART_BASE = glue_pkg::UART_BASE_ISA,
	parameter logic [15:0] ACK_BASE = glue_pkg::ACK_BASE_DEFAULT
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	glue_if.proc bus,
	input wire logic cmd_valid,
	input wire glue_pkg::cmd_t cmd_kind,
	input wire logic [19:0] cmd_addr,
	input wire logic [7:0] cmd_data,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic held,
	output logic [2:0] irq_pending
);
	import glue_pkg::*;

	localparam logic [19:0] MID_SPAN = 20'(1 << MID_AW);
	localparam logic [1:0] WAIT_LAST = 2'(INT_WAIT);

	proc_state_t state_r;
	logic [4:0] cfg_r;
	logic [1:0] cnt_r;
	logic ext_wait_r;
	logic second_r;
	logic take, issue2, finish;
	logic is_mem, is_io, in_lower, in_mid, in_uart, in_ack;
	logic [19:0] a;
	logic [7:0] d;
	cmd_t k;

	assign take = (state_r == P_IDLE) && cmd_ready && cmd_valid && !bus.cpu_hold;
	assign issue2 = (state_r == P_IDLE) && second_r && !bus.cpu_hold;
	assign k = issue2 ? CMD_IO_WR : (cmd_kind == CMD_HOST_INT ? CMD_IO_WR : cmd_kind);
	assign a = (issue2 || cmd_kind == CMD_HOST_INT) ? 20'(ISA_HOST_INTERRUPT) : cmd_addr;
	assign d = issue2 ? IRQ_PULSE_HIGH : (cmd_kind == CMD_HOST_INT ? IRQ_PULSE_LOW : cmd_data);
	assign is_mem = (k == CMD_MEM_RD) || (k == CMD_MEM_WR);
	assign is_io = (k == CMD_IO_RD) || (k == CMD_IO_WR);
	assign in_lower = cfg_r[CFG_LOWER_EN] && is_mem && (a <= LOWER_TOP);
	assign in_mid = cfg_r[CFG_MID_EN] && is_mem && (a >= MID_BASE) && (a - MID_BASE < MID_SPAN);
	assign in_uart = cfg_r[CFG_MID_EN] && is_mem && (a >= UART_BASE) &&
		(a - UART_BASE < UART_SPAN);
	assign in_ack = cfg_r[CFG_PERIPH_EN] && is_io && (a[15:3] == ACK_BASE[15:3]);
	assign finish = (state_r == P_ACCESS) && (ext_wait_r ? bus.ext_ready : (cnt_r == WAIT_LAST));

	// Chip selects stay off until software configures them after every release
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cfg_r <= 5'h00;
		end else if (ce) begin
			if (bus.cpu_hold)
				cfg_r <= 5'h00;
			else if (take && cmd_kind == CMD_CFG)
				cfg_r <= cmd_data[4:0];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= P_IDLE;
			cnt_r <= 2'h0;
			ext_wait_r <= 1'b0;
			second_r <= 1'b0;
			cmd_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data <= 8'h00;
			bus.addr <= 20'h00000;
			bus.wdata <= 8'h00;
			bus.mem_rd <= 1'b0;
			bus.mem_wr <= 1'b0;
			bus.io_rd <= 1'b0;
			bus.io_wr <= 1'b0;
			bus.lower_mem_select_n <= 1'b1;
			bus.dual_port_select_n <= 1'b1;
			bus.uart_bank_select_n <= 1'b1;
			bus.ack_peripheral_select_n <= 1'b1;
		end else if (ce) begin
			rsp_valid <= 1'b0;
			if (bus.cpu_hold) begin
				state_r <= P_IDLE;
				second_r <= 1'b0;
				cmd_ready <= 1'b0;
				bus.mem_rd <= 1'b0;
				bus.mem_wr <= 1'b0;
				bus.io_rd <= 1'b0;
				bus.io_wr <= 1'b0;
				bus.lower_mem_select_n <= 1'b1;
				bus.dual_port_select_n <= 1'b1;
				bus.uart_bank_select_n <= 1'b1;
				bus.ack_peripheral_select_n <= 1'b1;
			end else begin
				case (state_r)
					P_IDLE: begin
						cmd_ready <= !second_r && !(cmd_valid && cmd_ready);
						if ((take && cmd_kind != CMD_CFG) || issue2) begin
							state_r <= P_ACCESS;
							cmd_ready <= 1'b0;
							cnt_r <= 2'h0;
							second_r <= take && cmd_kind == CMD_HOST_INT;
							bus.addr <= a;
							bus.wdata <= d;
							bus.mem_rd <= k == CMD_MEM_RD;
							bus.mem_wr <= k == CMD_MEM_WR;
							bus.io_rd <= k == CMD_IO_RD;
							bus.io_wr <= k == CMD_IO_WR;
							bus.lower_mem_select_n <= !in_lower;
							bus.dual_port_select_n <= !in_mid;
							bus.uart_bank_select_n <= !in_uart;
							bus.ack_peripheral_select_n <= !in_ack;
							// Only blocks set up for external ready wait on the glue
							ext_wait_r <= ((in_mid || in_uart) && cfg_r[CFG_MID_EXT_RDY]) ||
								(in_ack && cfg_r[CFG_PERIPH_EXT_RDY]);
						end else if (take) begin
							rsp_valid <= 1'b1;
							rsp_data <= 8'h00;
						end
					end
					P_ACCESS: begin
						cnt_r <= cnt_r + 2'h1;
						if (finish) begin
							state_r <= P_IDLE;
							rsp_valid <= !second_r;
							rsp_data <= bus.rdata;
							bus.mem_rd <= 1'b0;
							bus.mem_wr <= 1'b0;
							bus.io_rd <= 1'b0;
							bus.io_wr <= 1'b0;
							bus.lower_mem_select_n <= 1'b1;
							bus.dual_port_select_n <= 1'b1;
							bus.uart_bank_select_n <= 1'b1;
							bus.ack_peripheral_select_n <= 1'b1;
						end
					end
					default: state_r <= P_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			held <= 1'b1;
			irq_pending <= 3'h0;
		end else if (ce) begin
			held <= bus.cpu_hold;
			irq_pending <= {bus.modem_irq_input, bus.tx_irq_input, bus.rx_irq_input};
		end
	end
endmodule // glue_proc

// ==== bench/glue_asserts.sv ====
// Protocol checker for the processor bus between the glue device and the processor end
`timescale 1ns/1ns
module glue_asserts
	import glue_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [19:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic io_rd,
	input wire logic io_wr,
	input wire logic lower_mem_select_n,
	input wire logic dual_port_select_n,
	input wire logic uart_bank_select_n,
	input wire logic ack_peripheral_select_n,
	input wire logic ext_ready,
	input wire logic cpu_hold,
	input wire logic rx_irq_input,
	input wire logic tx_irq_input,
	input wire logic modem_irq_input
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	logic any_strobe;
	logic mid_cycle;
	logic ack_cycle;
	assign any_strobe = mem_rd | mem_wr | io_rd | io_wr;
	assign mid_cycle = (mem_rd | mem_wr) & (!dual_port_select_n | !uart_bank_select_n);
	assign ack_cycle = io_rd & !ack_peripheral_select_n & (addr[2:0] inside {3'h0, 3'h2, 3'h4});
	// A held processor must not start cycles; two cycles of slack for the abort
	a_hold_no_cycles: assert property (cpu_hold && $past(cpu_hold) && $past(cpu_hold, 2)
		|-> !any_strobe) else $error("strobe while processor held");
	a_mid_ready_time: assert property ($rose(mid_cycle) |-> ##2 ext_ready)
		else $error("mid select cycle not ended by ready");
	a_ack_ready_time: assert property ($rose(ack_cycle) |-> ##2 ext_ready)
		else $error("acknowledge cycle not ended by ready");
	a_lower_int_ready: assert property (any_strobe && !lower_mem_select_n |-> !ext_ready)
		else $error("ready raised on lower memory cycle");
	a_ready_single: assert property (ext_ready |=> !ext_ready)
		else $error("ready longer than one cycle");
	a_ready_in_cycle: assert property (ext_ready |-> any_strobe)
		else $error("ready outside a bus cycle");
	a_dp_region: assert property (!dual_port_select_n |-> addr[19:14] == DP_BASE_ISA[19:14])
		else $error("dual port select outside its region");
	a_uart_region: assert property (!uart_bank_select_n |-> addr[19:10] == UART_BASE_ISA[19:10]
		&& !io_rd && !io_wr) else $error("uart select outside its region");
	a_lower_region: assert property (!lower_mem_select_n |-> addr[19:16] == 4'h0)
		else $error("lower select outside its region");
	c_dp_read: cover property ($rose(mem_rd && !dual_port_select_n));
	c_ack_read: cover property ($rose(ack_cycle));
	c_io_write: cover property ($rose(io_wr));
	c_hold: cover property ($fell(cpu_hold));
endmodule // glue_asserts

// ==== bench/tb_adapter_board_processor_glue.sv ====
// Testbench joining the glue device and the processor end through the processor bus
`timescale 1ns/1ns
module tb_adapter_board_processor_glue;
	import glue_pkg::*;
	logic clk = 1'b0, rstn = 1'b0, cmd_valid = 1'b0;
	logic download_pin = 1'b0, host_reset_pin = 1'b0, host_irq_clear_pin = 1'b0;
	logic [2:0] irq_pins = 3'h0;
	logic [7:0] ram_rdata = 8'h00, dp_rdata = 8'h00, uart_rdata = 8'h00, cmd_data = 8'h00;
	logic [19:0] cmd_addr = 20'h00000;
	cmd_t cmd_kind = CMD_CFG;
	logic ram_cpu_en, ram_host_en, ram_we, dp_en, dp_we, uart_rd, uart_wr, program_ready, host_irq;
	logic [15:0] ram_addr;
	logic [17:0] dp_addr, cap_dp;
	logic [3:0] uart_cs, cap_cs;
	logic [6:0] uart_off, cap_off;
	logic [2:0] uart_ack, cap_ack, irq_pending;
	logic [7:0] wdata_out, rsp_data, cap_wd;
	logic [16:0] cap_ram;
	logic cmd_ready, rsp_valid, held, ram_seen = 1'b0;
	logic program_ready_e, host_irq_e;
	int fail_count = 0;
	int compares = 0;
	always #10 clk = ~clk;
	glue_if bus_if();
	glue_device glue_device_inst (.clk(clk), .rstn(rstn), .ce(1'b1), .bus(bus_if),
		.download_pin(download_pin), .host_reset_pin(host_reset_pin),
		.host_irq_clear_pin(host_irq_clear_pin), .rx_irq_pin(irq_pins[0]),
		.tx_irq_pin(irq_pins[1]), .modem_irq_pin(irq_pins[2]), .ram_rdata(ram_rdata),
		.dp_rdata(dp_rdata), .uart_rdata(uart_rdata), .ram_cpu_en(ram_cpu_en),
		.ram_host_en(ram_host_en), .ram_we(ram_we), .ram_addr(ram_addr), .dp_en(dp_en),
		.dp_we(dp_we), .dp_addr(dp_addr), .uart_cs(uart_cs), .uart_rd(uart_rd),
		.uart_wr(uart_wr), .uart_off(uart_off), .uart_ack(uart_ack), .wdata_out(wdata_out),
		.program_ready(program_ready), .host_irq(host_irq));
	glue_proc glue_proc_inst (.clk(clk), .rstn(rstn), .ce(1'b1), .bus(bus_if),
		.cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
		.cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .held(held),
		.irq_pending(irq_pending));
	// Second pair in the other bus variant runs in lockstep on the same commands
	glue_if bus_e();
	glue_device #(.VARIANT(VAR_EISA)) glue_device_e_inst (.clk(clk), .rstn(rstn), .ce(1'b1),
		.bus(bus_e), .download_pin(download_pin), .host_reset_pin(host_reset_pin),
		.host_irq_clear_pin(host_irq_clear_pin), .rx_irq_pin(irq_pins[0]),
		.tx_irq_pin(irq_pins[1]), .modem_irq_pin(irq_pins[2]), .ram_rdata(ram_rdata),
		.dp_rdata(dp_rdata), .uart_rdata(uart_rdata), .ram_cpu_en(), .ram_host_en(),
		.ram_we(), .ram_addr(), .dp_en(), .dp_we(), .dp_addr(), .uart_cs(), .uart_rd(),
		.uart_wr(), .uart_off(), .uart_ack(), .wdata_out(), .program_ready(program_ready_e),
		.host_irq(host_irq_e));
	glue_proc glue_proc_e_inst (.clk(clk), .rstn(rstn), .ce(1'b1), .bus(bus_e),
		.cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
		.cmd_ready(), .rsp_valid(), .rsp_data(), .held(), .irq_pending());
	glue_asserts glue_asserts_inst (.clk(clk), .rstn(rstn), .addr(bus_if.addr),
		.wdata(bus_if.wdata), .rdata(bus_if.rdata), .mem_rd(bus_if.mem_rd),
		.mem_wr(bus_if.mem_wr), .io_rd(bus_if.io_rd), .io_wr(bus_if.io_wr),
		.lower_mem_select_n(bus_if.lower_mem_select_n),
		.dual_port_select_n(bus_if.dual_port_select_n),
		.uart_bank_select_n(bus_if.uart_bank_select_n),
		.ack_peripheral_select_n(bus_if.ack_peripheral_select_n),
		.ext_ready(bus_if.ext_ready), .cpu_hold(bus_if.cpu_hold),
		.rx_irq_input(bus_if.rx_irq_input), .tx_irq_input(bus_if.tx_irq_input),
		.modem_irq_input(bus_if.modem_irq_input));
	// Capture one-cycle enable pulses so the sequence can compare them afterwards
	always @(posedge clk) begin
		if (dp_en === 1'b1) cap_dp <= dp_addr;
		if (uart_wr === 1'b1) begin
			cap_cs <= uart_cs;
			cap_off <= uart_off;
			cap_wd <= wdata_out;
		end
		if (|uart_ack) cap_ack <= uart_ack;
		if (ram_cpu_en === 1'b1) begin
			ram_seen <= 1'b1;
			cap_ram <= {ram_we, ram_addr};
		end
	end
	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [19:0] seen, input logic [19:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic hang(input string name);
		fail_count++;
		$display("CHECK FAILED %s expected 1 seen 0", name);
		print_verdict();
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Ready is registered, so looking at it on the falling edge is race free
	task automatic run_cmd(input cmd_t k, input logic [19:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(negedge clk);
		while (cmd_ready !== 1'b1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		if (n >= 200) hang("cmd_ready");
		cmd_kind = k;
		cmd_addr = a;
		cmd_data = d;
		cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 50) begin
			@(negedge clk);
			n++;
		end
		if (n >= 50) hang("rsp_valid");
	endtask
	initial begin
		repeat (4) @(posedge clk);
		@(negedge clk);
		rstn = 1'b1;
		run_cmd(CMD_CFG, 20'h00000, 8'h1f);
		ram_rdata = 8'h3c;
		run_cmd(CMD_MEM_RD, 20'h00040, 8'h00);
		chk("lower_rdata", {12'h000, rsp_data}, 20'h0003c);
		chk("ram_cpu_en", {19'h0, ram_seen}, 20'h00001);
		chk("ram_addr", {3'h0, cap_ram}, 20'h00040);
		dp_rdata = 8'ha5;
		run_cmd(CMD_MEM_RD, DP_BASE_ISA + 20'h00123, 8'h00);
		chk("dp_rdata", {12'h000, rsp_data}, 20'h000a5);
		chk("dp_addr", {6'h00, cap_dp[13:0]}, 20'h00123);
		$display("test memory finished");
		for (int i = 0; i < 4; i++) begin
			run_cmd(CMD_MEM_WR, UART_BASE_ISA + 20'(i) * 20'h00100 + 20'h00080, 8'h11);
			chk("uart_cs", {16'h0000, cap_cs}, 20'(4'h1 << i));
			chk("uart_off", {13'h0000, cap_off}, 20'h00040);
			chk("uart_wdata", {12'h000, cap_wd}, 20'h00011);
		end
		$display("test uart finished");
		for (int i = 0; i < 3; i++) begin
			uart_rdata = 8'h50 + 8'(i);
			run_cmd(CMD_IO_RD, {4'h0, ACK_BASE_DEFAULT} + 20'(2 * i), 8'h00);
			chk("ack_rdata", {12'h000, rsp_data}, 20'h00050 + 20'(i));
			chk("uart_ack", {17'h00000, cap_ack}, 20'(3'h1 << i));
		end
		$display("test acknowledge finished");
		run_cmd(CMD_IO_WR, {4'h0, ISA_READY_SIGNAL}, 8'h00);
		wait_cyc(3);
		chk("program_ready", {19'h0, program_ready}, 20'h00001);
		chk("eisa_ready", {19'h0, program_ready_e}, 20'h00001);
		run_cmd(CMD_HOST_INT, 20'h00000, 8'h00);
		wait_cyc(3);
		chk("host_irq_pulse", {19'h0, host_irq}, 20'h00001);
		host_irq_clear_pin = 1'b1;
		wait_cyc(4);
		host_irq_clear_pin = 1'b0;
		chk("host_irq_clear", {19'h0, host_irq}, 20'h00000);
		run_cmd(CMD_IO_WR, {4'h0, ISA_HOST_INTERRUPT}, 8'h02);
		run_cmd(CMD_IO_WR, {4'h0, ISA_HOST_INTERRUPT}, 8'h03);
		wait_cyc(3);
		chk("host_irq_masked", {19'h0, host_irq}, 20'h00000);
		chk("eisa_irq_any_data", {19'h0, host_irq_e}, 20'h00001);
		run_cmd(CMD_IO_WR, {4'h0, ISA_HOST_INTERRUPT}, 8'h00);
		run_cmd(CMD_IO_WR, {4'h0, ISA_HOST_INTERRUPT}, 8'h01);
		wait_cyc(3);
		chk("host_irq_edge", {19'h0, host_irq}, 20'h00001);
		$display("test host interrupt finished");
		for (int i = 0; i < 3; i++) begin
			irq_pins = 3'(3'h1 << i);
			wait_cyc(6);
			chk("irq_pending", {17'h00000, irq_pending}, 20'(3'h1 << i));
			irq_pins = 3'h0;
			wait_cyc(6);
		end
		$display("test uart interrupts finished");
		download_pin = 1'b1;
		wait_cyc(8);
		chk("held_download", {19'h0, held}, 20'h00001);
		chk("ram_host_en", {19'h0, ram_host_en}, 20'h00001);
		chk("ready_cleared", {19'h0, program_ready}, 20'h00000);
		chk("eisa_ready_cleared", {19'h0, program_ready_e}, 20'h00000);
		download_pin = 1'b0;
		run_cmd(CMD_CFG, 20'h00000, 8'h1f);
		chk("ram_host_off", {19'h0, ram_host_en}, 20'h00000);
		$display("test download finished");
		host_reset_pin = 1'b1;
		wait_cyc(6);
		host_reset_pin = 1'b0;
		wait_cyc(20);
		chk("held_reset_min", {19'h0, held}, 20'h00001);
		wait_cyc(20);
		chk("held_released", {19'h0, held}, 20'h00000);
		$display("test host reset finished");
		print_verdict();
	end
endmodule // tb_adapter_board_processor_glue
